//--- hw/iq_conv_pkg.sv
package iq_conv_pkg;

  // Widths of the sample words on each bus.
  localparam int RX_WORD_W      = 8;
  localparam int TX_WORD_W      = 10;

  // Receive pipeline depth, in converter clock periods, output latch included.
  localparam int RX_LAT_CYC     = 5;

  // System clock and converter clock periods.
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CONV_PERIOD_NS = 100;
  localparam int CONV_HALF_RAW  = (CONV_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int CONV_HALF_CYC  = (CONV_HALF_RAW < 1) ? 1 : CONV_HALF_RAW;

  // Offset binary codes for bipolar zero after reset.
  localparam logic [RX_WORD_W-1:0] RX_ZERO_CODE = 8'h80;
  localparam logic [TX_WORD_W-1:0] TX_ZERO_CODE = 10'h200;

  // Serial mode port framing.
  localparam int SER_WORD_BITS  = 8;
  localparam int SER_CNT_W      = 3;
  localparam int MODE_CODE_W    = 3;
  localparam int PIN_SCLK       = 0;
  localparam int PIN_DIN        = 1;
  localparam int PIN_SELN       = 2;
  localparam logic [2:0] PIN_IDLE = 3'h4;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'b000,
    MODE_IDLE     = 3'b001,
    MODE_RX       = 3'b010,
    MODE_TX       = 3'b011,
    MODE_XCVR     = 3'b100,
    MODE_STANDBY  = 3'b101
  } mode_type;

  localparam mode_type MODE_RESET = MODE_SHUTDOWN;

  function automatic logic rx_on(input mode_type m);
    return (m == MODE_RX) || (m == MODE_XCVR);
  endfunction

  function automatic logic tx_on(input mode_type m);
    return (m == MODE_TX) || (m == MODE_XCVR);
  endfunction

endpackage

//--- hw/mode_serial_port.sv
`timescale 1ns/1ns
module mode_serial_port
  import iq_conv_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // Serial pins
  input  wire logic                   i_ser_clk,
  input  wire logic                   i_ser_data,
  input  wire logic                   i_ser_sel_n,
  // Decoded word
  output logic                        o_mode_stb,
  output logic [MODE_CODE_W-1:0]      o_mode_code
);

  typedef struct packed {
    logic [2:0]             s1;
    logic [2:0]             s2;
    logic [2:0]             s3;
    logic [2:0]             conf;
    logic [6:0]             shift;
    logic [SER_CNT_W-1:0]   cnt;
    logic                   stb;
    logic [MODE_CODE_W-1:0] code;
  } ser_state_type;

  ser_state_type q;
  ser_state_type d;
  logic          sclk_rise;

  always_comb begin
    d      = q;
    d.stb  = 1'b0;
    d.s1   = {i_ser_sel_n, i_ser_data, i_ser_clk};
    d.s2   = q.s1;
    d.s3   = q.s2;
    // A pin level counts only once the last two stages agree.
    d.conf = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.conf);
    sclk_rise = d.conf[PIN_SCLK] & ~q.conf[PIN_SCLK];
    if (q.conf[PIN_SELN]) begin
      d.cnt = '0;
    end else if (sclk_rise) begin
      if (q.cnt == SER_CNT_W'(SER_WORD_BITS - 1)) begin
        d.cnt  = '0;
        d.stb  = 1'b1;
        d.code = {q.shift[1:0], q.conf[PIN_DIN]};
      end else begin
        d.cnt   = q.cnt + 1'b1;
        d.shift = {q.shift[5:0], q.conf[PIN_DIN]};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, conf: PIN_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_mode_stb  = q.stb;
  assign o_mode_code = q.code;

  ser_bits_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.stb |-> $past(q.cnt) == SER_CNT_W'(SER_WORD_BITS - 1) && $past(!q.conf[PIN_SELN]))
    else $error("Mode word applied before eight bits.");

endmodule

//--- hw/iq_pair_buffer.sv
`timescale 1ns/1ns
module iq_pair_buffer #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  // Fill side
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [W-1:0]  i_in_data,
  // Drain side
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic [W-1:0]       o_out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wr;
    logic              rd;
    logic [1:0]        cnt;
    logic              ready;
  } buf_state_type;

  buf_state_type q;
  buf_state_type d;
  logic          push;
  logic          pop;

  always_comb begin
    d    = q;
    push = i_in_valid && q.ready;
    pop  = i_out_ready && (q.cnt != 2'h0);
    if (push) begin
      d.mem[q.wr] = i_in_data;
      d.wr        = ~q.wr;
    end
    if (pop) begin
      d.rd = ~q.rd;
    end
    d.cnt   = q.cnt + 2'(push) - 2'(pop);
    d.ready = (d.cnt != 2'h2);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_in_ready  = q.ready;
  assign o_out_valid = (q.cnt != 2'h0);
  assign o_out_data  = q.mem[q.rd];

  buf_full_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (q.cnt == 2'h2) |-> !o_in_ready)
    else $error("Buffer full but still ready.");

endmodule

//--- hw/iq_converter_parallel_port.sv
// Function
// - Both receive channels are sampled together on each converter clock rise.
// - One 8-bit bus carries in-phase on rise, quadrature on fall.
// - Receive latency is 5 periods in-phase, 5.5 periods quadrature.
// - Receive words are offset binary, bipolar zero is 1000 0000.
// - In-phase word taken on falling edge, quadrature word on rising edge.
// - Both transmit outputs update together on the next rising edge.
// - Transmit words are 10-bit offset binary, midscale 10 0000 0000.
// - Six operating states are chosen over the serial port.
// - Mode word low three bits select the state; upper bits ignored.
// - Mode word shifts in MSB first on serial clock rises, applied after eight.
// - Receive bus floats while off and resumes with the last word.
`timescale 1ns/1ns
module iq_converter_parallel_port
  import iq_conv_pkg::*;
#(
  parameter int RX_W   = RX_WORD_W,
  parameter int TX_W   = TX_WORD_W,
  parameter int RX_LAT = RX_LAT_CYC,
  parameter int HALF   = CONV_HALF_CYC
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_sys_rst,
  // Receive converter results
  input  wire logic [RX_W-1:0] i_rx_inphase_input,
  input  wire logic [RX_W-1:0] i_rx_quadrature_input,
  // Receive output bus
  output logic [RX_W-1:0]      o_rx_sample_bus,
  output logic                 o_rx_sample_bus_oe,
  // Transmit input bus
  input  wire logic [TX_W-1:0] i_tx_word_bus,
  output logic                 o_tx_word_ready,
  // Transmit converter words
  output logic [TX_W-1:0]      o_tx_inphase_output,
  output logic [TX_W-1:0]      o_tx_quadrature_output,
  // Converter clock and mode
  output logic                 o_conv_clk,
  output mode_type             o_mode,
  // Serial mode port pins
  input  wire logic            i_ser_clk,
  input  wire logic            i_ser_data,
  input  wire logic            i_ser_sel_n
);

  localparam int DIV_W     = (HALF > 1) ? $clog2(HALF) : 1;
  localparam int PAIR_W    = 2 * TX_W;
  localparam int RXI_PAST  = 2 * HALF * RX_LAT + 1;
  localparam int RXQ_PAST  = 2 * HALF * RX_LAT + HALF + 1;
  localparam int TXQ_PAST  = 2 * HALF + 1;
  localparam int TXI_PAST  = 3 * HALF + 1;
  localparam int RX_WARM   = 2 * HALF * RX_LAT + 2 * HALF + 2;

  typedef struct packed {
    logic [DIV_W-1:0]                div_cnt;
    logic                            conv_clk;
    logic                            rise;
    logic                            fall;
    logic                            popped;
    mode_type                        mode;
    logic [RX_LAT-1:0][2*RX_W-1:0]   pipe;
    logic [RX_W-1:0]                 q_hold;
    logic [RX_W-1:0]                 rx_bus;
    logic                            rx_oe;
    logic [TX_W-1:0]                 i_hold;
    logic [TX_W-1:0]                 tx_i;
    logic [TX_W-1:0]                 tx_q;
  } port_state_type;

  port_state_type           q;
  port_state_type           d;
  logic                     rise;
  logic                     fall;
  logic                     mode_stb;
  logic [MODE_CODE_W-1:0]   mode_code;
  logic                     push;
  logic                     pop;
  logic                     buf_ready;
  logic                     buf_valid;
  logic [PAIR_W-1:0]        buf_data;

  mode_serial_port u_serial (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_ser_clk   (i_ser_clk),
    .i_ser_data  (i_ser_data),
    .i_ser_sel_n (i_ser_sel_n),
    .o_mode_stb  (mode_stb),
    .o_mode_code (mode_code)
  );

  // A stalled pair waits here while the transmit side is off.
  iq_pair_buffer #(
    .W (PAIR_W)
  ) u_buffer (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .o_in_ready  (buf_ready),
    .i_in_data   ({q.i_hold, i_tx_word_bus}),
    .o_out_valid (buf_valid),
    .i_out_ready (pop),
    .o_out_data  (buf_data)
  );

  // Pairs are taken only in a transmitting mode.
  assign push = rise && tx_on(q.mode);
  assign pop  = rise && tx_on(q.mode) && buf_valid;

  always_comb begin
    d        = q;
    rise     = 1'b0;
    fall     = 1'b0;
    // The converter clock is a divided copy; its edges are one-cycle enables.
    if (q.div_cnt == DIV_W'(HALF - 1)) begin
      d.div_cnt  = '0;
      d.conv_clk = ~q.conv_clk;
      rise       = ~q.conv_clk;
      fall       = q.conv_clk;
    end else begin
      d.div_cnt = q.div_cnt + 1'b1;
    end
    d.rise   = rise;
    d.fall   = fall;
    d.popped = pop;

    if (mode_stb && (mode_code <= MODE_CODE_W'(MODE_STANDBY))) begin
      d.mode = mode_type'(mode_code);
    end
    d.rx_oe = rx_on(d.mode);

    if (rise) begin
      d.pipe = {q.pipe[RX_LAT-2:0], i_rx_inphase_input, i_rx_quadrature_input};
    end
    if (rise && rx_on(q.mode)) begin
      d.rx_bus = q.pipe[RX_LAT-1][2*RX_W-1:RX_W];
      d.q_hold = q.pipe[RX_LAT-1][RX_W-1:0];
    end
    if (fall && rx_on(q.mode)) begin
      d.rx_bus = q.q_hold;
    end

    if (fall) begin
      d.i_hold = i_tx_word_bus;
    end
    // Joint output update.
    // The buffered pair is kept through shutdown, but the outputs return to midscale.
    if (rise && (q.mode == MODE_SHUTDOWN)) begin
      d.tx_i = TX_ZERO_CODE;
      d.tx_q = TX_ZERO_CODE;
    end else if (pop) begin
      d.tx_i = buf_data[PAIR_W-1:TX_W];
      d.tx_q = buf_data[TX_W-1:0];
    end
  end

  // Receive bus starts at bipolar zero.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{mode: MODE_RESET, pipe: {RX_LAT{RX_ZERO_CODE, RX_ZERO_CODE}},
             q_hold: RX_ZERO_CODE, rx_bus: RX_ZERO_CODE, i_hold: TX_ZERO_CODE,
             tx_i: TX_ZERO_CODE, tx_q: TX_ZERO_CODE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_rx_sample_bus        = q.rx_bus;
  assign o_rx_sample_bus_oe     = q.rx_oe;
  assign o_tx_word_ready        = buf_ready;
  assign o_tx_inphase_output    = q.tx_i;
  assign o_tx_quadrature_output = q.tx_q;
  assign o_conv_clk             = q.conv_clk;
  assign o_mode                 = q.mode;

  // Cycles for which the receive bus has been driven, for the latency checks.
  logic [7:0] on_cnt;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      on_cnt <= '0;
    end else if (!q.rx_oe) begin
      on_cnt <= '0;
    end else if (on_cnt != 8'hff) begin
      on_cnt <= on_cnt + 1'b1;
    end
  end

  sequence rx_rise_s;
    q.rise && (on_cnt > 8'(RX_WARM));
  endsequence

  sequence rx_fall_s;
    q.fall && (on_cnt > 8'(RX_WARM));
  endsequence

  sequence tx_pop_s;
    q.popped && $past(push && buf_ready, TXQ_PAST);
  endsequence

  lat_inphase_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rx_rise_s |-> o_rx_sample_bus == $past(i_rx_inphase_input, RXI_PAST))
    else $error("In-phase receive latency wrong.");

  lat_quad_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rx_fall_s |-> o_rx_sample_bus == $past(i_rx_quadrature_input, RXQ_PAST))
    else $error("Quadrature receive latency wrong.");

  bus_edge_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_rx_sample_bus) |-> (q.rise || q.fall) && $past(o_rx_sample_bus_oe))
    else $error("Receive bus changed off a converter edge.");

  hold_last_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_rx_sample_bus_oe |=> $stable(o_rx_sample_bus))
    else $error("Receive word changed while bus is off.");

  bus_resume_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_rx_sample_bus_oe) |-> $stable(o_rx_sample_bus))
    else $error("Bus did not resume with the last word.");

  bus_enable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rx_sample_bus_oe == ((o_mode == MODE_RX) || (o_mode == MODE_XCVR)))
    else $error("Receive bus enable disagrees with mode.");

  tx_pair_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tx_pop_s |-> o_tx_quadrature_output == $past(i_tx_word_bus, TXQ_PAST)
                 && o_tx_inphase_output == $past(i_tx_word_bus, TXI_PAST))
    else $error("Transmit pair captured on wrong edges.");

  tx_update_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(o_tx_inphase_output) || $changed(o_tx_quadrature_output)) |-> q.rise)
    else $error("Transmit outputs changed off a rising edge.");

  mode_apply_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_stb && mode_code <= 3'h5) |=> o_mode == mode_type'($past(mode_code)))
    else $error("Mode word not applied.");

  mode_ignore_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode_stb && mode_code > 3'h5) |=> $stable(o_mode))
    else $error("Reserved mode code changed the state.");

  // The converter clock must follow its own edge enables, or every lane above drifts.
  sequence conv_edge_s;
    q.rise || q.fall;
  endsequence

  conv_edge_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    conv_edge_s |-> $changed(o_conv_clk))
    else $error("Converter clock did not toggle on its edge.");

  conv_rise_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.rise |-> o_conv_clk)
    else $error("Converter rise enable without a high clock.");

  conv_fall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    q.fall |-> !o_conv_clk)
    else $error("Converter fall enable without a low clock.");

  // A rise seen while shut down must leave both transmit words at midscale.
  sequence shut_rise_s;
    q.rise && ($past(o_mode) == MODE_SHUTDOWN);
  endsequence

  tx_shut_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    shut_rise_s |-> (o_tx_inphase_output == TX_ZERO_CODE)
                    && (o_tx_quadrature_output == TX_ZERO_CODE))
    else $error("Transmit outputs not at midscale in shutdown.");

  // Outside the transmitting modes nothing is popped, so apart from shutdown the outputs must hold.
  tx_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!tx_on($past(o_mode)) && ($past(o_mode) != MODE_SHUTDOWN))
      |-> $stable(o_tx_inphase_output) && $stable(o_tx_quadrature_output))
    else $error("Transmit outputs changed while transmit is off.");

  rx_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !rx_on($past(o_mode)) |-> $stable(o_rx_sample_bus))
    else $error("Receive word changed while receive is off.");

endmodule

//--- sim/host_model.sv
`timescale 1ns/1ns
module host_model
  import iq_conv_pkg::*;
(
  // Clock and converter state
  input  wire logic                 i_clk,
  input  wire logic                 i_conv_clk,
  input  wire mode_type             i_mode,
  // Pair to send
  input  wire logic [TX_WORD_W-1:0] i_pair_i,
  input  wire logic [TX_WORD_W-1:0] i_pair_q,
  // Transmit bus and serial pins
  output logic [TX_WORD_W-1:0]      o_tx_word_bus,
  output logic                      o_ser_clk,
  output logic                      o_ser_data,
  output logic                      o_ser_sel_n
);
  initial begin
    o_tx_word_bus = '0;
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_sel_n = 1'b1;
  end

  // Bus held at zero while transmit is off.
  // Converter clock comes from the device at 10 MHz.
  // The old converter clock level tells which word the coming cycle wants.
  always @(posedge i_clk) begin
    if (!tx_on(i_mode)) begin
      o_tx_word_bus <= '0;
    end else if (i_conv_clk == 1'b0) begin
      o_tx_word_bus <= i_pair_i;
    end else begin
      o_tx_word_bus <= i_pair_q;
    end
  end

  // Mode word MSB first.
  // Four cycles per phase keeps each level past the three-flop synchroniser.
  task automatic write_mode(input logic [SER_WORD_BITS-1:0] word);
    @(posedge i_clk);
    o_ser_sel_n <= 1'b0;
    for (int b = SER_WORD_BITS - 1; b >= 0; b--) begin
      repeat (4) @(posedge i_clk);
      o_ser_data <= word[b];
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ser_clk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_ser_sel_n <= 1'b1;
    o_ser_data <= ~o_ser_data;
    repeat (16) @(posedge i_clk);
  endtask
endmodule

//--- sim/tb_iq_converter_parallel_port.sv
`timescale 1ns/1ns
module tb_iq_converter_parallel_port
  import iq_conv_pkg::*;
;
  logic                 clk;
  logic                 rst;
  logic [7:0]           cyc;
  logic [7:0]           rx_i;
  logic [7:0]           rx_q;
  logic [7:0]           bus;
  logic                 oe;
  logic [9:0]           tx_bus;
  logic                 ready;
  logic [9:0]           out_i;
  logic [9:0]           out_q;
  logic                 conv_clk;
  mode_type             mode;
  logic                 sclk;
  logic                 sdata;
  logic                 seln;
  logic [9:0]           pair_i;
  logic [9:0]           pair_q;
  logic                 rx_chk;
  logic [7:0]           held;
  int                   failures;
  int                   num_checks;

  iq_converter_parallel_port dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_rx_inphase_input(rx_i),
    .i_rx_quadrature_input(rx_q), .o_rx_sample_bus(bus), .o_rx_sample_bus_oe(oe),
    .i_tx_word_bus(tx_bus), .o_tx_word_ready(ready), .o_tx_inphase_output(out_i),
    .o_tx_quadrature_output(out_q), .o_conv_clk(conv_clk), .o_mode(mode),
    .i_ser_clk(sclk), .i_ser_data(sdata), .i_ser_sel_n(seln));

  host_model host_u (
    .i_clk(clk), .i_conv_clk(conv_clk), .i_mode(mode), .i_pair_i(pair_i),
    .i_pair_q(pair_q), .o_tx_word_bus(tx_bus), .o_ser_clk(sclk),
    .o_ser_data(sdata), .o_ser_sel_n(seln));

  task automatic chk_w(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The input value names its own cycle, so latency is read off the code seen.
  always @(posedge clk) begin
    cyc <= cyc + 8'd1;
    rx_i <= cyc + 8'd1;
    rx_q <= ~(cyc + 8'd1);
  end

  always @(negedge clk) begin
    if (rx_chk) begin
      chk_w("rx bus enable", 10'h001, {9'h000, oe});
      if (conv_clk === 1'b1) begin
        chk_w("rx inphase", {2'b00, cyc - 8'd11}, {2'b00, bus});
      end else begin
        chk_w("rx quadrature", {2'b00, ~(cyc - 8'd12)}, {2'b00, bus});
      end
    end
  end

  task automatic t_reset();
    chk_w("reset mode", 10'h000, {7'h00, mode});
    chk_w("reset rx bus", {2'b00, RX_ZERO_CODE}, {2'b00, bus});
    chk_w("reset enable", 10'h000, {9'h000, oe});
    chk_w("reset tx i", TX_ZERO_CODE, out_i);
    chk_w("reset tx q", TX_ZERO_CODE, out_q);
  endtask

  task automatic t_modes();
    for (int c = 0; c < 6; c++) begin
      host_u.write_mode({5'h15, c[2:0]});
      chk_w("mode", {7'h00, c[2:0]}, {7'h00, mode});
      chk_w("mode enable", {9'h000, (c == 2 || c == 4)}, {9'h000, oe});
    end
    host_u.write_mode(8'hFE);
    chk_w("reserved mode", {7'h00, MODE_STANDBY}, {7'h00, mode});
  endtask

  task automatic t_rx_freeze();
    host_u.write_mode({5'h00, MODE_RX});
    repeat (20) @(negedge clk);
    rx_chk = 1'b1;
    repeat (300) @(negedge clk);
    rx_chk = 1'b0;
    host_u.write_mode({5'h00, MODE_TX});
    held = bus;
    repeat (9) @(negedge clk);
    chk_w("frozen bus", {2'b00, held}, {2'b00, bus});
    chk_w("off enable", 10'h000, {9'h000, oe});
    fork
      host_u.write_mode({5'h00, MODE_RX});
      begin
        for (int n = 0; n < 200 && oe !== 1'b1; n++) @(negedge clk);
        chk_w("resume word", {2'b00, held}, {2'b00, bus});
      end
    join
  endtask

  task automatic t_tx();
    logic [9:0] vi [4];
    logic [9:0] vq [4];
    vi = '{10'h3FF, 10'h200, 10'h000, 10'h155};
    vq = '{10'h000, 10'h1FF, 10'h3FF, 10'h2AA};
    host_u.write_mode({5'h00, MODE_XCVR});
    rx_chk = 1'b1;
    for (int k = 0; k < 4; k++) begin
      do @(posedge clk); while (conv_clk !== 1'b1);
      pair_i <= vi[k];
      pair_q <= vq[k];
      for (int n = 0; n < 20 && out_i !== vi[k]; n++) @(negedge clk);
      chk_w("tx i", vi[k], out_i);
      chk_w("tx q same edge", vq[k], out_q);
      chk_w("tx ready", 10'h001, {9'h000, ready});
    end
    rx_chk = 1'b0;
    host_u.write_mode({5'h00, MODE_SHUTDOWN});
    chk_w("shutdown tx i", TX_ZERO_CODE, out_i);
    chk_w("shutdown tx q", TX_ZERO_CODE, out_q);
  endtask

  initial begin
    failures = 0;
    num_checks = 0;
    rst = 1'b1;
    cyc = 8'h00;
    rx_i = 8'h00;
    rx_q = 8'hFF;
    pair_i = 10'h000;
    pair_q = 10'h000;
    rx_chk = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_modes();
    t_rx_freeze();
    t_tx();
    end_of_test();
  end

  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule
